// file: verilog/uart_fc_regs.svh
/*
   Constants of the serial port: clock rate, baud range, oversampling and frame figures.
   Assumes a single 100 MHz system clock; definitions only.
*/
`ifndef UART_FC_REGS_SVH
`define UART_FC_REGS_SVH

`define UFC_CLK_HZ 100000000
`define UFC_OVERSAMPLE 16
`define UFC_BAUD_MIN 1200
`define UFC_BAUD_MAX 460800
// cycles per oversample tick at the fastest and slowest rates, rounded down
`define UFC_DIV_MIN (`UFC_CLK_HZ / (`UFC_OVERSAMPLE * `UFC_BAUD_MAX))
`define UFC_DIV_MAX (`UFC_CLK_HZ / (`UFC_OVERSAMPLE * `UFC_BAUD_MIN))
`define UFC_DIV_W 13
`define UFC_DATA_W 8
`define UFC_LAST_TICK 4'hF
`define UFC_MID_TICK 4'h7
`define UFC_LAST_BIT 3'h7

`endif

// file: verilog/uart_fc_pkg.sv
/*
   Types shared by the serial port core and its serialiser and deserialiser.
   Assumes the constants header is included where figures are needed.
*/
package uart_fc_pkg;
   typedef logic [7:0] char_t;
   typedef enum logic [4:0] {
      FR_IDLE = 5'h01,
      FR_START = 5'h02,
      FR_DATA = 5'h04,
      FR_PARITY = 5'h08,
      FR_STOP = 5'h10
   } frame_state_e;
   typedef struct packed {
      char_t data;
      logic parityErr;
      logic frameErr;
   } rx_char_s;
endpackage : uart_fc_pkg

// file: verilog/uart_frame_if.sv
/*
   Link between the port core and its bit-level transmitter and receiver.
   Assumes all three sit on the same clock; the core drives tick and configuration.
*/
`timescale 1ns/1ns
interface uart_frame_if;
   import uart_fc_pkg::*;
   logic tick;
   logic parityEn;
   logic parityOdd;
   logic txStart;
   char_t txData;
   logic txBusy;
   logic rxDone;
   rx_char_s rxChar;
   modport core (output tick, parityEn, parityOdd, txStart, txData,
                 input txBusy, rxDone, rxChar);
   modport tx (input tick, parityEn, parityOdd, txStart, txData, output txBusy);
   modport rx (input tick, parityEn, parityOdd, output rxDone, rxChar);
endinterface : uart_frame_if

// file: verilog/uart_tx_serial.sv
/*
   Character serialiser: start bit, data LSB first, optional parity, one stop bit.
   Assumes the core pulses txStart only while txBusy is low and gives 16 ticks per bit.
*/
`timescale 1ns/1ns
`include "uart_fc_regs.svh"
module uart_tx_serial (
   input wire logic mclk,
   input wire logic sys_rst,
   uart_frame_if.tx link,
   output logic txLine
);
   import uart_fc_pkg::*;
   frame_state_e state;
   logic [3:0] tickCnt;
   logic [2:0] bitIdx;
   char_t shift;
   logic par;

   assign link.txBusy = (state != FR_IDLE);

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state <= FR_IDLE;
         txLine <= 1'b1;
         tickCnt <= 4'h0;
         bitIdx <= 3'h0;
         shift <= 8'h00;
         par <= 1'b0;
      end else begin
         case (state)
            FR_IDLE: begin
               txLine <= 1'b1;
               if (link.txStart) begin
                  shift <= link.txData;
                  par <= ^link.txData ^ link.parityOdd;
                  tickCnt <= 4'h0;
                  txLine <= 1'b0;
                  state <= FR_START;
               end
            end
            default: begin
               if (link.tick) begin
                  tickCnt <= tickCnt + 4'h1;
                  if (tickCnt == `UFC_LAST_TICK) begin
                     case (state)
                        FR_START: begin
                           txLine <= shift[0];
                           bitIdx <= 3'h0;
                           state <= FR_DATA;
                        end
                        FR_DATA: begin
                           bitIdx <= bitIdx + 3'h1;
                           shift <= {1'b0, shift[7:1]};
                           if (bitIdx != `UFC_LAST_BIT) begin
                              txLine <= shift[1];
                           end else if (link.parityEn) begin
                              txLine <= par;
                              state <= FR_PARITY;
                           end else begin
                              txLine <= 1'b1;
                              state <= FR_STOP;
                           end
                        end
                        FR_PARITY: begin
                           txLine <= 1'b1;
                           state <= FR_STOP;
                        end
                        default: begin
                           txLine <= 1'b1;
                           state <= FR_IDLE;
                        end
                     endcase
                  end
               end
            end
         endcase
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   chk_start_bit_low: assert property (state == FR_START |-> !txLine)
      else $error("start bit not low");
   chk_stop_bit_high: assert property (state == FR_STOP |-> txLine)
      else $error("stop bit not high");
endmodule : uart_tx_serial

// file: verilog/uart_rx_serial.sv
/*
   Character deserialiser, always listening, sampling each bit at its centre.
   Assumes 16 ticks per bit from the core; the line is synchronous to mclk.
*/
`timescale 1ns/1ns
`include "uart_fc_regs.svh"
module uart_rx_serial (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic rxLine,
   uart_frame_if.rx link
);
   import uart_fc_pkg::*;
   frame_state_e state;
   logic [3:0] tickCnt;
   logic [2:0] bitIdx;
   char_t shift;
   logic parErr;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state <= FR_IDLE;
         tickCnt <= 4'h0;
         bitIdx <= 3'h0;
         shift <= 8'h00;
         parErr <= 1'b0;
         link.rxDone <= 1'b0;
         link.rxChar <= '0;
      end else begin
         link.rxDone <= 1'b0;
         case (state)
            FR_IDLE: begin
               // no enable: a start bit may come at any moment
               if (!rxLine) begin
                  tickCnt <= 4'h0;
                  parErr <= 1'b0;
                  state <= FR_START;
               end
            end
            FR_START: begin
               if (link.tick) begin
                  tickCnt <= tickCnt + 4'h1;
                  if (tickCnt == `UFC_MID_TICK) begin
                     tickCnt <= 4'h0;
                     bitIdx <= 3'h0;
                     // a glitch shorter than half a bit is not a start
                     state <= rxLine ? FR_IDLE : FR_DATA;
                  end
               end
            end
            default: begin
               if (link.tick) begin
                  tickCnt <= tickCnt + 4'h1;
                  if (tickCnt == `UFC_LAST_TICK) begin
                     case (state)
                        FR_DATA: begin
                           shift <= {rxLine, shift[7:1]};
                           bitIdx <= bitIdx + 3'h1;
                           if (bitIdx == `UFC_LAST_BIT) begin
                              state <= link.parityEn ? FR_PARITY : FR_STOP;
                           end
                        end
                        FR_PARITY: begin
                           parErr <= rxLine ^ (^shift) ^ link.parityOdd;
                           state <= FR_STOP;
                        end
                        default: begin
                           link.rxDone <= 1'b1;
                           link.rxChar <= '{data: shift, parityErr: parErr,
                                            frameErr: !rxLine};
                           // back to idle at mid-stop so the next start edge is seen
                           state <= FR_IDLE;
                        end
                     endcase
                  end
               end
            end
         endcase
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   chk_frame_err_flag: assert property (link.rxDone |-> link.rxChar.frameErr == !$past(rxLine))
      else $error("framing error does not match stop sample");
   chk_start_detect: assert property (state == FR_IDLE && !rxLine |=> state == FR_START)
      else $error("start edge missed");
   chk_parity_off: assert property (link.rxDone && !link.parityEn |-> !link.rxChar.parityErr)
      else $error("parity error with parity off");
endmodule : uart_rx_serial

// file: verilog/uart_flow_control_port.sv
/*
   Full-duplex serial port with RTS/CTS flow control, parity and a two-slot receive buffer.
   Assumes pins are synchronous to mclk; pad pulls and drive are set through enable outputs.
*/
`timescale 1ns/1ns
`include "uart_fc_regs.svh"
module uart_flow_control_port #(
   parameter logic [12:0] DIV_MAX = 13'(`UFC_DIV_MAX)
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [12:0] baudDivisor,
   input wire logic parityEn,
   input wire logic parityOdd,
   input wire uart_fc_pkg::char_t txData,
   input wire logic txValid,
   output logic txReady,
   output uart_fc_pkg::char_t rxData,
   output logic rxParityErr,
   output logic rxFrameErr,
   output logic rxValid,
   input wire logic rxReady,
   output logic rxOverrun,
   input wire logic overrunClear,
   output logic gpio_pin_twentyone,
   input wire logic gpio_pin_twentytwo,
   output logic gpio_pin_twentythree,
   input wire logic gpio_pin_twentyfour,
   output logic txPinOeN,
   output logic rtsPinOeN,
   output logic rxPullUpEn,
   output logic ctsPullDownEn
);
   import uart_fc_pkg::*;

   uart_frame_if link ();

   logic [12:0] divCnt;
   logic [12:0] divEff;
   logic pinsReady;
   logic ctsAsserted;
   char_t txHold;
   logic txHoldFull;
   logic launch;
   rx_char_s rxHead;
   rx_char_s rxSpare;
   logic spareFull;
   logic push;
   logic pop;
   logic overrunEvt;
   logic next_headBusy;

   // keeps a divisor inside the supported rate range
   function automatic logic [12:0] clampDiv(input logic [12:0] d);
      if (d < 13'(`UFC_DIV_MIN)) begin
         clampDiv = 13'(`UFC_DIV_MIN);
      end else if (d > DIV_MAX) begin
         clampDiv = DIV_MAX;
      end else begin
         clampDiv = d;
      end
   endfunction : clampDiv

   assign divEff = clampDiv(baudDivisor);

   // one oversample tick every divEff cycles, shared by both directions
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         divCnt <= 13'h0000;
         link.tick <= 1'b0;
      end else if (divCnt >= divEff - 13'h0001) begin
         divCnt <= 13'h0000;
         link.tick <= 1'b1;
      end else begin
         divCnt <= divCnt + 13'h0001;
         link.tick <= 1'b0;
      end
   end

   assign link.parityEn = parityEn;
   assign link.parityOdd = parityOdd;

   // pad setup is applied on the first edge after reset and held from then on
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pinsReady <= 1'b0;
         txPinOeN <= 1'b1;
         rtsPinOeN <= 1'b1;
         rxPullUpEn <= 1'b0;
         ctsPullDownEn <= 1'b0;
      end else begin
         pinsReady <= 1'b1;
         txPinOeN <= 1'b0;
         rtsPinOeN <= 1'b0;
         rxPullUpEn <= 1'b1;
         ctsPullDownEn <= 1'b1;
      end
   end

   // with the pull-down an open clear-to-send reads as asserted
   assign ctsAsserted = !gpio_pin_twentyfour;

   // transmit side: one holding register in front of the serialiser
   assign txReady = !txHoldFull;
   assign launch = txHoldFull && !link.txBusy && !link.txStart && ctsAsserted;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         txHold <= 8'h00;
         txHoldFull <= 1'b0;
         link.txStart <= 1'b0;
         link.txData <= 8'h00;
      end else begin
         link.txStart <= launch;
         if (txValid && txReady) begin
            txHold <= txData;
            txHoldFull <= 1'b1;
         end else if (launch) begin
            // a frame in flight is never cut short, only the next one waits
            link.txData <= txHold;
            txHoldFull <= 1'b0;
         end
      end
   end

   uart_tx_serial txUnit (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .link(link.tx),
      .txLine(gpio_pin_twentyone)
   );

   uart_rx_serial rxUnit (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .rxLine(gpio_pin_twentytwo),
      .link(link.rx)
   );

   // receive side: head slot drives the outputs, spare slot catches the frame in flight
   assign push = link.rxDone;
   assign pop = rxValid && rxReady;
   assign overrunEvt = push && !pop && rxValid && spareFull;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rxHead <= '0;
         rxSpare <= '0;
         rxValid <= 1'b0;
         spareFull <= 1'b0;
      end else if (pop) begin
         if (spareFull) begin
            rxHead <= rxSpare;
            spareFull <= push;
            if (push) begin
               rxSpare <= link.rxChar;
            end
         end else if (push) begin
            rxHead <= link.rxChar;
         end else begin
            rxValid <= 1'b0;
         end
      end else if (push) begin
         if (!rxValid) begin
            rxHead <= link.rxChar;
            rxValid <= 1'b1;
         end else if (!spareFull) begin
            // room for one more frame that the host began before seeing RTS fall
            rxSpare <= link.rxChar;
            spareFull <= 1'b1;
         end
      end
   end

   assign rxData = rxHead.data;
   assign rxParityErr = rxHead.parityErr;
   assign rxFrameErr = rxHead.frameErr;

   // sticky overrun; a new overrun in the clearing cycle keeps the flag set
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rxOverrun <= 1'b0;
      end else if (overrunEvt) begin
         rxOverrun <= 1'b1;
      end else if (overrunClear) begin
         rxOverrun <= 1'b0;
      end
   end

   // stop asking once the head is taken; the spare absorbs the frame already under way
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         gpio_pin_twentythree <= 1'b1;
      end else begin
         gpio_pin_twentythree <= !(pinsReady && !next_headBusy);
      end
   end

   always_comb begin
      next_headBusy = rxValid;
      if (pop && !spareFull && !push) begin
         next_headBusy = 1'b0;
      end else if (push && !rxValid) begin
         next_headBusy = 1'b1;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence launchReady;
      txHoldFull && !link.txBusy && !link.txStart && ctsAsserted;
   endsequence
   sequence frameBegins;
      link.txStart ##1 link.txBusy;
   endsequence

   chk_tx_launch: assert property (launchReady |=> frameBegins)
      else $error("held character not launched");
   chk_cts_pause: assert property ($rose(link.txBusy) |-> $past(ctsAsserted, 2))
      else $error("frame started while clear-to-send off");
   chk_tx_idle_high: assert property (!link.txBusy && !link.txStart |=> gpio_pin_twentyone)
      else $error("transmit line low while idle");
   // rts is registered from the next head state, so it tracks rxValid in the same cycle
   chk_rts_full: assert property (rxValid |-> gpio_pin_twentythree)
      else $error("request-to-send asserted with full buffer");
   chk_rts_ready: assert property (pinsReady && !rxValid && !push |=> !gpio_pin_twentythree)
      else $error("request-to-send not asserted with empty buffer");
   chk_overrun_drop: assert property (overrunEvt |=> rxOverrun && $stable(rxHead) && spareFull)
      else $error("overrun not flagged or data changed");
   chk_pin_setup: assert property (pinsReady |-> !txPinOeN && rxPullUpEn && ctsPullDownEn)
      else $error("pads not configured after reset");
   chk_tick_space: assert property (link.tick |=> !link.tick [*8])
      else $error("oversample ticks too close");
endmodule : uart_flow_control_port

// file: bench/uart_host_model.sv
/*
   Behavioural host: frame sender that honours request-to-send, frame decoder, clear-to-send.
   Assumes BIT matches the port's bit time in mclk cycles.
*/
`timescale 1ns/1ns
module uart_host_model #(
   parameter int BIT = 208
) (
   input wire logic mclk,
   input wire logic devTx,
   input wire logic rtsN,
   input wire logic parEn,
   output logic hostTx,
   output logic ctsN
);
   logic [9:0] rxQ[$];
   initial begin
      hostTx = 1'h1;
      ctsN = 1'h0;
   end
   task automatic setCts(input logic v);
      @(posedge mclk);
      #1;
      ctsN = v;
   endtask : setCts
   task automatic bitOut(input logic v, input int n);
      #1;
      hostTx = v;
      repeat (n) @(posedge mclk);
   endtask : bitOut
   // a stop bit short of a full bit time but past its centre makes a framing fault
   task automatic send(input logic [7:0] d, input logic usePar, input logic par,
      input logic stopHigh, input logic obey);
      if (obey) begin
         wait (rtsN === 1'h0);
      end
      @(posedge mclk);
      bitOut(1'h0, BIT);
      for (int i = 0; i < 8; i++) begin
         bitOut(d[i], BIT);
      end
      if (usePar) begin
         bitOut(par, BIT);
      end
      if (!stopHigh) begin
         bitOut(1'h0, BIT * 5 / 8);
      end
      bitOut(1'h1, BIT);
   endtask : send
   // samples at bit centres; pushes {stop, parity, data}
   initial begin : decode
      logic [9:0] f;
      forever begin
         @(negedge devTx);
         repeat (BIT / 2) @(posedge mclk);
         if (devTx === 1'h0) begin
            f = 10'h0;
            for (int i = 0; i < 8; i++) begin
               repeat (BIT) @(posedge mclk);
               f[i] = devTx;
            end
            if (parEn) begin
               repeat (BIT) @(posedge mclk);
               f[8] = devTx;
            end
            repeat (BIT) @(posedge mclk);
            f[9] = devTx;
            rxQ.push_back(f);
         end
      end
   end
endmodule : uart_host_model

// file: bench/uart_flow_control_port_tb.sv
/*
   Self-checking bench for the flow-controlled serial port against a host model.
   Assumes a divisor of 13 with DIV_MAX shortened to 20.
*/
`timescale 1ns/1ns
module uart_flow_control_port_tb;
   import uart_fc_pkg::*;
   localparam int BIT = 16 * 13;
   logic mclk = 1'h0;
   logic sys_rst = 1'h1;
   logic parityEn = 1'h0;
   logic parityOdd = 1'h0;
   char_t txData = 8'h00;
   logic txValid = 1'h0;
   logic rxReady = 1'h0;
   logic overrunClear = 1'h0;
   char_t rxData;
   logic txReady, rxParityErr, rxFrameErr, rxValid, rxOverrun;
   logic txPin, rxPin, rtsPin, ctsPin, txPinOeN, rtsPinOeN, rxPullUpEn, ctsPullDownEn;
   int error_cnt = 0;
   int n_tests = 0;
   always #5 mclk = ~mclk;
   uart_flow_control_port #(.DIV_MAX(13'h14)) u_uart_flow_control_port (
      .mclk(mclk), .sys_rst(sys_rst), .baudDivisor(13'hD), .parityEn(parityEn),
      .parityOdd(parityOdd), .txData(txData), .txValid(txValid), .txReady(txReady),
      .rxData(rxData), .rxParityErr(rxParityErr), .rxFrameErr(rxFrameErr),
      .rxValid(rxValid), .rxReady(rxReady), .rxOverrun(rxOverrun),
      .overrunClear(overrunClear), .gpio_pin_twentyone(txPin), .gpio_pin_twentytwo(rxPin),
      .gpio_pin_twentythree(rtsPin), .gpio_pin_twentyfour(ctsPin), .txPinOeN(txPinOeN),
      .rtsPinOeN(rtsPinOeN), .rxPullUpEn(rxPullUpEn), .ctsPullDownEn(ctsPullDownEn));
   uart_host_model #(.BIT(BIT)) u_uart_host_model (.mclk(mclk), .devTx(txPin),
      .rtsN(rtsPin), .parEn(parityEn), .hostTx(rxPin), .ctsN(ctsPin));
   function automatic logic parOf(input char_t d);
      return (^d) ^ parityOdd;
   endfunction : parOf
   task automatic check(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'h1) begin
         error_cnt++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic putTx(input char_t d);
      int k;
      k = 0;
      cyc(1);
      txData = d;
      txValid = 1'h1;
      // txReady changes just after a clock edge; hold the offer until an edge sees it high
      while (txReady !== 1'h1 && k < 20000) begin
         cyc(1);
         k++;
      end
      cyc(1);
      txValid = 1'h0;
      if (k >= 20000) check(1'h0, "tx offer never taken");
   endtask : putTx
   task automatic getHost(input char_t d);
      logic [9:0] f;
      int k;
      k = 0;
      while (u_uart_host_model.rxQ.size() == 0 && k < 5000) begin
         cyc(1);
         k++;
      end
      f = (u_uart_host_model.rxQ.size() > 0) ? u_uart_host_model.rxQ.pop_front() : 10'h0;
      check(f[7:0] === d && f[9] === 1'h1 && (!parityEn || f[8] === parOf(d)), "line char");
   endtask : getHost
   task automatic popRx(input char_t d, input logic pe, input logic fe);
      int k;
      k = 0;
      cyc(1);
      while (rxValid !== 1'h1 && k < 5000) begin
         cyc(1);
         k++;
      end
      check(rxValid === 1'h1 && rxData === d && rxParityErr === pe && rxFrameErr === fe,
         "received char");
      rxReady = 1'h1;
      cyc(1);
      rxReady = 1'h0;
   endtask : popRx
   task automatic hostSend(input char_t d, input logic badPar, input logic stopHigh,
      input logic obey);
      u_uart_host_model.send(d, parityEn, parOf(d) ^ badPar, stopHigh, obey);
   endtask : hostSend
   task automatic t_reset();
      cyc(8);
      check(txPin === 1'h1 && txPinOeN === 1'h1 && rtsPin === 1'h1, "pins in reset");
      sys_rst = 1'h0;
      cyc(1);
      check(txPinOeN === 1'h0 && txPin === 1'h1, "tx pin driven high");
      check(rxPullUpEn === 1'h1, "rx pull-up");
      check(ctsPullDownEn === 1'h1, "cts pull-down");
      cyc(1);
      check(rtsPinOeN === 1'h0 && rtsPin === 1'h0, "rts driven low");
   endtask : t_reset
   task automatic t_tx();
      char_t d;
      for (int m = 0; m < 3; m++) begin
         cyc(BIT);
         parityEn = (m != 0);
         parityOdd = (m == 2);
         d = 8'h96 ^ 8'(m);
         putTx(d);
         putTx(~d);
         getHost(d);
         getHost(~d);
      end
      cyc(BIT);
      check(txPin === 1'h1, "idle line high");
   endtask : t_tx
   task automatic t_cts();
      logic quiet;
      quiet = 1'h1;
      u_uart_host_model.setCts(1'h1);
      cyc(4);
      putTx(8'h5A);
      repeat (3 * BIT) begin
         @(posedge mclk);
         if (txPin !== 1'h1) quiet = 1'h0;
      end
      check(quiet, "tx held while cts off");
      u_uart_host_model.setCts(1'h0);
      getHost(8'h5A);
   endtask : t_cts
   task automatic t_rx();
      char_t d;
      for (int m = 0; m < 3; m++) begin
         cyc(BIT);
         parityEn = (m != 0);
         parityOdd = (m == 2);
         d = 8'hC3 ^ 8'(m);
         hostSend(d, 1'h0, 1'h1, 1'h1);
         popRx(d, 1'h0, 1'h0);
      end
      hostSend(8'h41, 1'h1, 1'h1, 1'h1);
      popRx(8'h41, 1'h1, 1'h0);
      hostSend(8'h7E, 1'h0, 1'h0, 1'h1);
      cyc(BIT);
      popRx(8'h7E, 1'h0, 1'h1);
      fork
         putTx(8'hE7);
         hostSend(8'h18, 1'h0, 1'h1, 1'h1);
      join
      getHost(8'hE7);
      popRx(8'h18, 1'h0, 1'h0);
   endtask : t_rx
   task automatic t_flow();
      hostSend(8'h11, 1'h0, 1'h1, 1'h1);
      cyc(4);
      check(rtsPin === 1'h1, "rts off when head full");
      hostSend(8'h22, 1'h0, 1'h1, 1'h0);
      check(rxOverrun === 1'h0, "spare slot takes one more");
      hostSend(8'h33, 1'h0, 1'h1, 1'h0);
      check(rxOverrun === 1'h1, "overrun flagged");
      popRx(8'h11, 1'h0, 1'h0);
      popRx(8'h22, 1'h0, 1'h0);
      cyc(3);
      check(rxValid === 1'h0 && rtsPin === 1'h0, "third char dropped, rts on");
      overrunClear = 1'h1;
      cyc(1);
      overrunClear = 1'h0;
      cyc(1);
      check(rxOverrun === 1'h0, "overrun cleared");
   endtask : t_flow
   task automatic results();
      $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results
   initial begin
      #1;
      t_reset();
      t_tx();
      t_cts();
      t_rx();
      t_flow();
      results();
   end
   // frames run about 2300 cycles each; the limit leaves ample margin
   initial begin
      repeat (100000) @(posedge mclk);
      error_cnt++;
      $display("unexpected at %0t: watchdog expired", $time);
      results();
   end
endmodule : uart_flow_control_port_tb
